/* File: rtl/obcd_key_chk.v */
`timescale 1ns/10ps
`include "obcd_map.vh"
// Flags a key byte that holds a forbidden all-zero or all-one value
module obcd_key_chk #(
   parameter W = 8
) (
   // Key in
   input  wire [W-1:0] key,
   // Result
   output wire         bad
);

   // Forbidden values
   assign bad = (key == `OBCD_KEY_LOW) | (key == `OBCD_KEY_HIGH);  // R11

endmodule

/* File: rtl/obcd_opt_mem.v */
`timescale 1ns/10ps
// Option byte store, kept across resets, registered read data
module obcd_opt_mem #(
   parameter DEPTH  = 16,
   parameter AW     = 4
) (
   // Clock
   input  wire          pclk,
   input  wire          ce,
   // Write port
   input  wire          wr_en,
   input  wire [AW-1:0] wr_addr,
   input  wire [7:0]    wr_data,
   // Read port
   input  wire          rd_en,
   input  wire [AW-1:0] rd_addr,
   output reg  [7:0]    rd_data
);

   reg [7:0] mem_q [0:DEPTH-1];

   // Array write and registered read
   always @(posedge pclk) begin
      if (ce) begin
         if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
         end
         if (rd_en) begin
            rd_data <= mem_q[rd_addr];
         end
      end
   end

endmodule

/* File: rtl/obcd_top.v */
`timescale 1ns/10ps
`include "obcd_map.vh"

// Overview of operation
// R1 - Trim option bit picks 3-bit trimming when clear, 4-bit when set.
// R2 - Slow clock bit set lets the low speed clock feed the CPU.
// R3 - Independent watchdog starts by hardware when its bit is set.
// R4 - Window watchdog activated by hardware when its bit is set.
// R5 - Active window watchdog plus halt-reset bit makes Halt produce a reset.
// R6 - External clock bit: clear is crystal, set is clock on input pin.
// R7 - Wakeup unit gets slow internal clock when clear, prescaled oscillator when set.
// R8 - Prescale code 01, 10, 11 for 16, 8, 4 MHz; 00 reserved.
// R9 - Settle byte E1, D2, B4, 00 gives 0.5, 8, 128, 2048 cycles.
// R10 - Unprotect field 0101 disables temporary unprotection; other values enable it.
// R11 - Programmer must keep each key byte away from 0x00 and 0xFF.
// R12 - Options load once after reset and stay fixed until next reset.
module obcd_top #(
   parameter ADDR_W = 8
) (
   // APB slave
   input  wire              pclk,
   input  wire              presetn,
   input  wire              ce,
   input  wire              psel,
   input  wire              penable,
   input  wire              pwrite,
   input  wire [ADDR_W-1:0] paddr,
   input  wire [31:0]       pwdata,
   output wire              pready,
   output wire              pslverr,
   output wire [31:0]       prdata,
   // Watchdog and halt inputs
   input  wire              window_dog_active,
   input  wire              halt_entry,
   // Configuration release
   output wire              cfg_valid,
   // Clock controller
   output wire              rc_trim_width_sel,
   output wire              slow_clock_cpu_allow,
   output wire              ext_clock_input_sel,
   output wire [12:0]       osc_settle_half_cycles,
   // Watchdogs
   output wire              indep_dog_auto_start,
   output wire              window_dog_auto_start,
   output wire              window_dog_halt_reset,
   output wire              halt_reset_req,
   // Auto-wakeup unit
   output wire              wakeup_clock_sel,
   output wire [1:0]        wakeup_prescale_code,
   // Memory protection
   output wire              temp_unprotect_enable,
   output wire [7:0]        temp_unprotect_key0,
   output wire [7:0]        temp_unprotect_key1,
   output wire [7:0]        temp_unprotect_key2,
   output wire [7:0]        temp_unprotect_key3
);

   // ----------------------------------------------------------------
   // Loader states
   // ----------------------------------------------------------------
   localparam [1:0] ST_IDLE   = 2'b00;
   localparam [1:0] ST_LOAD   = 2'b01;
   localparam [1:0] ST_DECODE = 2'b10;
   localparam [1:0] ST_DONE   = 2'b11;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   reg  [1:0]  state_q;
   reg  [1:0]  state_d;
   reg  [3:0]  idx_q;
   reg  [3:0]  idx_d;
   reg  [3:0]  cap_idx_q;
   reg         cap_vld_q;
   reg  [7:0]  raw_cw_q;
   reg  [7:0]  raw_ow_q;
   reg  [7:0]  raw_st_q;
   reg  [7:0]  raw_up_q;
   reg  [7:0]  key_q [0:3];
   reg         loaded_q;
   reg         trim_q;
   reg         slow_q;
   reg         ind_hw_q;
   reg         win_hw_q;
   reg         halt_q;
   reg         ext_q;
   reg         wake_q;
   reg  [1:0]  wakeup_prescale_code_q;
   reg  [12:0] settle_q;
   reg         settle_bad_q;
   reg         unprot_q;
   reg         halt_req_q;
   reg         rd_ok_q;
   reg  [31:0] prdata_q;
   reg  [12:0] settle_d;
   reg         settle_bad_d;
   reg  [31:0] rdata_d;
   reg         map_ok;
   wire [3:0]  key_bad;
   wire [7:0]  mem_rd_data;
   wire [3:0]  reg_idx;
   wire        apb_access;
   wire        apb_wr;
   wire        apb_rd;
   wire        mem_wr;
   wire        mem_rd;
   wire        idx_in_range;

   // ----------------------------------------------------------------
   // Option byte store
   // ----------------------------------------------------------------
   obcd_opt_mem #(
      .DEPTH   (16),
      .AW      (4)
   ) u_mem (
      .pclk    (pclk),
      .ce      (ce),
      .wr_en   (mem_wr),
      .wr_addr (reg_idx),
      .wr_data (pwdata[7:0]),
      .rd_en   (mem_rd),
      .rd_addr (idx_q),
      .rd_data (mem_rd_data)
   );

   // ----------------------------------------------------------------
   // Key sanity checks
   // ----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_key
         obcd_key_chk #(
            .W   (8)
         ) u_chk (
            .key (key_q[gi]),
            .bad (key_bad[gi])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   assign reg_idx      = paddr[5:2];
   assign apb_access   = psel & penable;
   assign idx_in_range = (reg_idx >= `OBCD_IDX_FIRST) & (reg_idx <= `OBCD_IDX_LAST);
   assign apb_wr       = ce & apb_access & pwrite;
   assign apb_rd       = ce & apb_access & ~pwrite & ~rd_ok_q;
   // Writes program the store only; live values change at next reset
   assign mem_wr       = apb_wr & map_ok & idx_in_range &
                         (reg_idx != `OBCD_IDX_RSVD);                       // R12
   assign mem_rd       = (state_q == ST_LOAD);

   // Legal addresses: status, live view and option words
   always @* begin
      map_ok = 1'b0;
      if ((paddr[ADDR_W-1:6] == {(ADDR_W-6){1'b0}}) && (paddr[1:0] == 2'b00)) begin
         map_ok = idx_in_range | (reg_idx == `OBCD_IDX_STATUS) |
                  (reg_idx == `OBCD_IDX_LIVE);
      end
   end

   // Writes finish at once, reads after one wait state
   assign pready  = ce & apb_access & (pwrite | rd_ok_q);
   assign pslverr = pready & ~map_ok;
   assign prdata  = prdata_q;

   // Read data multiplexer
   always @* begin
      rdata_d = 32'h0000_0000;
      case (reg_idx)
         `OBCD_IDX_STATUS: begin
            rdata_d[`OBCD_ST_LOADED]     = loaded_q;
            rdata_d[`OBCD_ST_WAKEUP_PRESCALE_CODE_RSVD]  = (wakeup_prescale_code_q == `OBCD_WAKEUP_PRESCALE_CODE_RSVD);
            rdata_d[`OBCD_ST_SETTLE_BAD] = settle_bad_q;
            rdata_d[`OBCD_ST_KEYBAD_LO+3:`OBCD_ST_KEYBAD_LO] = key_bad;
         end
         `OBCD_IDX_LIVE: begin
            rdata_d[0] = window_dog_active;
            rdata_d[1] = halt_entry;
            rdata_d[2] = unprot_q;
         end
         4'h3: rdata_d[7:0] = raw_cw_q;
         4'h4: rdata_d[7:0] = raw_ow_q;
         4'h5: rdata_d[7:0] = raw_st_q;
         4'h6: rdata_d[7:0] = raw_up_q;
         4'h8: rdata_d[7:0] = key_q[0];
         4'h9: rdata_d[7:0] = key_q[1];
         4'hA: rdata_d[7:0] = key_q[2];
         4'hB: rdata_d[7:0] = key_q[3];
         default: rdata_d = 32'h0000_0000;
      endcase
      if (!map_ok) begin
         rdata_d = 32'h0000_0000;
      end
   end

   // Read wait state and data register
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_ok_q  <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else if (ce) begin
         if (apb_rd) begin
            rd_ok_q  <= 1'b1;
            prdata_q <= rdata_d;
         end else if (pready) begin
            rd_ok_q  <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Loader sequence
   // ----------------------------------------------------------------
   // Next state: walk indices, then decode once
   always @* begin
      state_d = state_q;
      idx_d   = idx_q;
      case (state_q)
         ST_IDLE: begin
            state_d = ST_LOAD;
            idx_d   = `OBCD_IDX_FIRST;
         end
         ST_LOAD: begin
            if (idx_q == `OBCD_IDX_LAST) begin
               state_d = ST_DECODE;
            end else begin
               idx_d = idx_q + 4'h1;
            end
         end
         ST_DECODE: begin
            state_d = ST_DONE;
         end
         ST_DONE: begin
            state_d = ST_DONE;                                              // R12
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // State register and capture pipeline tag
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q   <= ST_IDLE;
         idx_q     <= 4'h0;
         cap_idx_q <= 4'h0;
         cap_vld_q <= 1'b0;
      end else if (ce) begin
         state_q   <= state_d;
         idx_q     <= idx_d;
         cap_idx_q <= idx_q;
         cap_vld_q <= mem_rd;
      end
   end

   // Raw option bytes captured one cycle after each read
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         raw_cw_q <= `OBCD_RST_BYTE;
         raw_ow_q <= `OBCD_RST_BYTE;
         raw_st_q <= `OBCD_RST_BYTE;
         raw_up_q <= `OBCD_RST_UNPROT;
         key_q[0] <= `OBCD_RST_BYTE;
         key_q[1] <= `OBCD_RST_BYTE;
         key_q[2] <= `OBCD_RST_BYTE;
         key_q[3] <= `OBCD_RST_BYTE;
      end else if (ce && cap_vld_q) begin
         case (cap_idx_q)
            `OBCD_IDX_CLKDOG:  raw_cw_q <= mem_rd_data;                     // R12
            `OBCD_IDX_OSCWAKE: raw_ow_q <= mem_rd_data;
            `OBCD_IDX_SETTLE:  raw_st_q <= mem_rd_data;
            `OBCD_IDX_UNPROT:  raw_up_q <= mem_rd_data;
            4'h8:              key_q[0] <= mem_rd_data;
            4'h9:              key_q[1] <= mem_rd_data;
            4'hA:              key_q[2] <= mem_rd_data;
            4'hB:              key_q[3] <= mem_rd_data;
            default:           raw_cw_q <= raw_cw_q;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   // Settle byte to half-cycle count; unknown codes take the longest wait
   always @* begin
      settle_d     = `OBCD_SETTLE_HALF3;
      settle_bad_d = 1'b0;
      case (raw_st_q)
         `OBCD_SETTLE_CODE0: settle_d = `OBCD_SETTLE_HALF0;                 // R9
         `OBCD_SETTLE_CODE1: settle_d = `OBCD_SETTLE_HALF1;                 // R9
         `OBCD_SETTLE_CODE2: settle_d = `OBCD_SETTLE_HALF2;                 // R9
         `OBCD_SETTLE_CODE3: settle_d = `OBCD_SETTLE_HALF3;                 // R9
         default: begin
            settle_d     = `OBCD_SETTLE_HALF3;
            settle_bad_d = 1'b1;
         end
      endcase
   end

   // Decoded configuration, written once per reset
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         loaded_q     <= 1'b0;
         trim_q       <= 1'b0;
         slow_q       <= 1'b0;
         ind_hw_q     <= 1'b0;
         win_hw_q     <= 1'b0;
         halt_q       <= 1'b0;
         ext_q        <= 1'b0;
         wake_q       <= 1'b0;
         wakeup_prescale_code_q       <= 2'b00;
         settle_q     <= `OBCD_SETTLE_HALF3;
         settle_bad_q <= 1'b0;
         unprot_q     <= 1'b0;
      end else if (ce && (state_q == ST_DECODE)) begin
         loaded_q     <= 1'b1;                                              // R12
         trim_q       <= raw_cw_q[`OBCD_CW_TRIM4];                          // R1
         slow_q       <= raw_cw_q[`OBCD_CW_SLOW_CPU];                       // R2
         ind_hw_q     <= raw_cw_q[`OBCD_CW_IND_HW];                         // R3
         win_hw_q     <= raw_cw_q[`OBCD_CW_WIN_HW];                         // R4
         halt_q       <= raw_cw_q[`OBCD_CW_HALT_RST];                       // R5
         ext_q        <= raw_ow_q[`OBCD_OW_EXT_CLK];                        // R6
         wake_q       <= raw_ow_q[`OBCD_OW_WAKE_SEL];                       // R7
         wakeup_prescale_code_q       <= raw_ow_q[`OBCD_OW_WAKEUP_PRESCALE_CODE_HI:`OBCD_OW_WAKEUP_PRESCALE_CODE_LO];       // R8
         settle_q     <= settle_d;                                          // R9
         settle_bad_q <= settle_bad_d;
         unprot_q     <= (raw_up_q[3:0] != `OBCD_UNPROT_OFF);               // R10
      end
   end

   // ----------------------------------------------------------------
   // Halt reset request
   // ----------------------------------------------------------------
   // Reset on Halt only when the window watchdog runs and the bit is set
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         halt_req_q <= 1'b0;
      end else if (ce) begin
         halt_req_q <= loaded_q & halt_q & window_dog_active & halt_entry;  // R5
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Downstream units stay held until the decode step has run
   assign cfg_valid              = loaded_q;                                // R12
   assign rc_trim_width_sel      = trim_q;
   assign slow_clock_cpu_allow   = slow_q;
   assign ext_clock_input_sel    = ext_q;
   assign osc_settle_half_cycles = settle_q;
   assign indep_dog_auto_start   = ind_hw_q;
   assign window_dog_auto_start  = win_hw_q;
   assign window_dog_halt_reset  = halt_q;
   assign halt_reset_req         = halt_req_q;
   assign wakeup_clock_sel       = wake_q;
   // Reserved code 00 passed through; status flags it
   assign wakeup_prescale_code   = wakeup_prescale_code_q;
   assign temp_unprotect_enable  = unprot_q;
   // Keys released only with the configuration
   assign temp_unprotect_key0    = loaded_q ? key_q[0] : `OBCD_RST_BYTE;
   assign temp_unprotect_key1    = loaded_q ? key_q[1] : `OBCD_RST_BYTE;
   assign temp_unprotect_key2    = loaded_q ? key_q[2] : `OBCD_RST_BYTE;
   assign temp_unprotect_key3    = loaded_q ? key_q[3] : `OBCD_RST_BYTE;

endmodule

/* File: shared/obcd_map.vh */
`ifndef OBCD_MAP_VH
`define OBCD_MAP_VH

// ----------------------------------------------------------------
// Register word indices (byte address = index * 4)
// ----------------------------------------------------------------
`define OBCD_IDX_STATUS    4'h0
`define OBCD_IDX_LIVE      4'h1
`define OBCD_IDX_CLKDOG    4'h3
`define OBCD_IDX_OSCWAKE   4'h4
`define OBCD_IDX_SETTLE    4'h5
`define OBCD_IDX_UNPROT    4'h6
`define OBCD_IDX_RSVD      4'h7
`define OBCD_IDX_KEY0      4'h8
`define OBCD_IDX_KEY3      4'hB
`define OBCD_IDX_FIRST     4'h3
`define OBCD_IDX_LAST      4'hB

// ----------------------------------------------------------------
// Field positions in clock_watchdog_options
// ----------------------------------------------------------------
`define OBCD_CW_HALT_RST   0
`define OBCD_CW_WIN_HW     1
`define OBCD_CW_IND_HW     2
`define OBCD_CW_SLOW_CPU   3
`define OBCD_CW_TRIM4      4

// ----------------------------------------------------------------
// Field positions in oscillator_wakeup_options
// ----------------------------------------------------------------
`define OBCD_OW_WAKEUP_PRESCALE_CODE_LO    0
`define OBCD_OW_WAKEUP_PRESCALE_CODE_HI    1
`define OBCD_OW_WAKE_SEL   2
`define OBCD_OW_EXT_CLK    3

// ----------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------
`define OBCD_ST_LOADED     0
`define OBCD_ST_WAKEUP_PRESCALE_CODE_RSVD  1
`define OBCD_ST_SETTLE_BAD 2
`define OBCD_ST_KEYBAD_LO  4

// ----------------------------------------------------------------
// Codes and counts
// ----------------------------------------------------------------
`define OBCD_WAKEUP_PRESCALE_CODE_RSVD     2'b00
`define OBCD_UNPROT_OFF    4'b0101
`define OBCD_SETTLE_CODE0  8'hE1
`define OBCD_SETTLE_CODE1  8'hD2
`define OBCD_SETTLE_CODE2  8'hB4
`define OBCD_SETTLE_CODE3  8'h00
`define OBCD_SETTLE_HALF0  13'h0001
`define OBCD_SETTLE_HALF1  13'h0010
`define OBCD_SETTLE_HALF2  13'h0100
`define OBCD_SETTLE_HALF3  13'h1000
`define OBCD_KEY_LOW       8'h00
`define OBCD_KEY_HIGH      8'hFF

// ----------------------------------------------------------------
// Reset values of the active configuration
// ----------------------------------------------------------------
`define OBCD_RST_BYTE      8'h00
`define OBCD_RST_UNPROT    8'h05

`endif

/* File: verification/obcd_dog_model.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Window watchdog and halt source
// ----------------------------------------
module obcd_dog_model #(
   parameter DELAY = 1
) (
   // Clock and reset
   input  logic pclk,
   input  logic presetn,
   // From decoder
   input  logic window_dog_auto_start,
   // From bench
   input  logic sw_start,
   input  logic halt_go,
   // To decoder
   output logic window_dog_active,
   output logic halt_entry
);
   int cnt_q;

   // Running when started by option or by software
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) window_dog_active <= 1'b0;
      else window_dog_active <= window_dog_auto_start | sw_start;
   end

   // One halt pulse, DELAY cycles after a request
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q      <= 0;
         halt_entry <= 1'b0;
      end else begin
         halt_entry <= (cnt_q == 1);
         if (halt_go) cnt_q <= DELAY;
         else if (cnt_q != 0) cnt_q <= cnt_q - 1;
      end
   end
endmodule

/* File: verification/obcd_top_asserts.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Port checker for the option decoder
// ----------------------------------------
module obcd_chk #(
   parameter ADDR_W = 8
) (
   // Clock, reset, bus
   input logic              pclk,
   input logic              presetn,
   input logic              ce,
   input logic              psel,
   input logic              penable,
   input logic              pwrite,
   input logic [ADDR_W-1:0] paddr,
   input logic              pready,
   input logic              pslverr,
   // Watchdog side
   input logic              window_dog_active,
   input logic              halt_entry,
   input logic              halt_reset_req,
   // Configuration
   input logic              cfg_valid,
   input logic              rc_trim_width_sel,
   input logic              slow_clock_cpu_allow,
   input logic              ext_clock_input_sel,
   input logic [12:0]       osc_settle_half_cycles,
   input logic              indep_dog_auto_start,
   input logic              window_dog_auto_start,
   input logic              window_dog_halt_reset,
   input logic              wakeup_clock_sel,
   input logic [1:0]        wakeup_prescale_code,
   input logic              temp_unprotect_enable,
   input logic [7:0]        temp_unprotect_key0,
   input logic [7:0]        temp_unprotect_key1,
   input logic [7:0]        temp_unprotect_key2,
   input logic [7:0]        temp_unprotect_key3
);
   // Gathered outputs and halt cause
   wire [31:0] keys_all   = {temp_unprotect_key3, temp_unprotect_key2,
                             temp_unprotect_key1, temp_unprotect_key0};
   wire [54:0] cfg_all    = {rc_trim_width_sel, slow_clock_cpu_allow, ext_clock_input_sel,
                             indep_dog_auto_start, window_dog_auto_start, window_dog_halt_reset,
                             wakeup_clock_sel, temp_unprotect_enable, wakeup_prescale_code,
                             osc_settle_half_cycles, keys_all};
   wire        halt_cause = cfg_valid & window_dog_halt_reset & window_dog_active & halt_entry;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Bus walks
   sequence s_rd_first;
      psel && penable && !pwrite && ce && !$past(penable) && paddr == 'h0C;
   endsequence
   sequence s_rd_answer;
      !pready ##1 pready;
   endsequence
   sequence s_wr_access;
      psel && penable && pwrite && ce;
   endsequence

   property p_rd_walk;   s_rd_first |-> s_rd_answer; endproperty
   property p_wr_walk;   s_wr_access |-> pready; endproperty
   property p_err_ready; pslverr |-> pready && psel && penable; endproperty
   property p_cfg_hold;  cfg_valid |=> cfg_valid; endproperty
   property p_cfg_fixed; cfg_valid && $past(cfg_valid) |-> $stable(cfg_all); endproperty
   property p_halt_req;  halt_reset_req == $past(halt_cause); endproperty
   property p_settle;
      cfg_valid |-> osc_settle_half_cycles inside {13'h0001, 13'h0010, 13'h0100, 13'h1000};
   endproperty
   property p_gated;     !cfg_valid |-> keys_all == 32'h0000_0000 && !temp_unprotect_enable;
   endproperty
   property p_load_time; ce && $rose(presetn) |-> ##[1:20] cfg_valid; endproperty

   a_rd_walk: assert property (p_rd_walk)
      else $error("read answer not after one wait state");
   a_wr_walk: assert property (p_wr_walk)
      else $error("write not answered at once");
   a_err_ready: assert property (p_err_ready)
      else $error("error outside access");
   a_cfg_hold: assert property (p_cfg_hold)
      else $error("cfg_valid dropped");
   a_cfg_fixed: assert property (p_cfg_fixed)
      else $error("configuration changed after load");
   a_halt_req: assert property (p_halt_req)
      else $error("halt reset request mismatch");
   a_settle: assert property (p_settle)
      else $error("settle count not a legal value");
   a_gated: assert property (p_gated)
      else $error("keys or unprotect before load");
   a_load_time: assert property (p_load_time)
      else $error("load too slow");
endmodule

bind obcd_top obcd_chk #(.ADDR_W(ADDR_W)) u_chk (.*);

/* File: verification/obcd_top_test.sv */
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin num_errors++; \
   $display("wrong value %s expected %0h seen %0h", nm, ex, gt); end end

module obcd_top_test;
   // ----------------------------------------
   // Stimulus and observed signals
   // ----------------------------------------
   logic        pclk     = 1'b0;
   logic        presetn  = 1'b0;
   logic        ce       = 1'b1;
   logic        psel     = 1'b0;
   logic        penable  = 1'b0;
   logic        pwrite   = 1'b0;
   logic [7:0]  paddr    = 8'h00;
   logic [31:0] pwdata   = 32'h0000_0000;
   logic        sw_start = 1'b0;
   logic        halt_go  = 1'b0;
   wire         pready, pslverr, cfg_valid, window_dog_active, halt_entry, halt_reset_req;
   wire  [31:0] prdata;
   wire         rc_trim_width_sel, slow_clock_cpu_allow, ext_clock_input_sel;
   wire  [12:0] osc_settle_half_cycles;
   wire         indep_dog_auto_start, window_dog_auto_start, window_dog_halt_reset;
   wire         wakeup_clock_sel, temp_unprotect_enable;
   wire  [1:0]  wakeup_prescale_code;
   wire  [7:0]  temp_unprotect_key0, temp_unprotect_key1, temp_unprotect_key2;
   wire  [7:0]  temp_unprotect_key3;
   int          num_errors  = 0;
   int          check_count = 0;
   logic [31:0] rd;
   logic        err;

   always #12.5 pclk = ~pclk;

   obcd_top dut (.*);
   obcd_dog_model #(.DELAY(3)) partner (.*);

   // One APB transfer, waits for pready
   task apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= {24'h00_0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(negedge pclk);
      // Judged mid-cycle: the level that stands at the next rising edge
      while (pready !== 1'b1 && n < 20) begin
         @(negedge pclk);
         n++;
      end
      if (n == 20) num_errors++;
      rd = prdata;
      err = pslverr;
      @(posedge pclk);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // Reset pulse, then bounded wait for the load
   task do_reset;
      int n;
      n = 0;
      @(posedge pclk);
      presetn <= 1'b0;
      @(posedge pclk);
      #1;
      `CHK("cfg_valid low", 1'b0, cfg_valid)
      `CHK("settle reset", 13'h1000, osc_settle_half_cycles)
      @(posedge pclk);
      presetn <= 1'b1;
      while (cfg_valid !== 1'b1 && n < 20) begin
         @(posedge pclk);
         n++;
      end
      #1;
      `CHK("cfg_valid", 1'b1, cfg_valid)
   endtask

   // Halt request, watch for the reset request
   task halt_try(input logic ex);
      logic seen;
      seen = 1'b0;
      @(posedge pclk);
      halt_go <= 1'b1;
      @(posedge pclk);
      halt_go <= 1'b0;
      repeat (8) begin
         @(negedge pclk);
         if (halt_reset_req === 1'b1) seen = 1'b1;
      end
      `CHK("halt reset", ex, seen)
   endtask

   // Unmapped and reserved places
   task t_bus;
      apb(1'b0, 8'h08, 8'h00);
      `CHK("gap error", 1'b1, err)
      apb(1'b1, 8'h1C, 8'h5A);
      apb(1'b0, 8'h1C, 8'h00);
      `CHK("reserved read", 32'h0000_0000, rd)
      `CHK("reserved error", 1'b0, err)
      apb(1'b0, 8'h30, 8'h00);
      `CHK("high error", 1'b1, err)
   endtask

   // Program, reset, check every decoded field
   task t_decode;
      logic [4:0]  cw [4] = '{5'h1F, 5'h00, 5'h15, 5'h0A};
      logic [3:0]  ow [4] = '{4'hD, 4'h2, 4'h7, 4'h9};
      logic [7:0]  st [4] = '{8'hE1, 8'hD2, 8'hB4, 8'h00};
      logic [3:0]  un [4] = '{4'h5, 4'hA, 4'h0, 4'hF};
      logic [12:0] hf [4] = '{13'h0001, 13'h0010, 13'h0100, 13'h1000};
      logic [3:0]  k;
      for (int i = 0; i < 4; i++) begin
         k = i[3:0] + 4'h1;
         apb(1'b1, 8'h0C, {3'b000, cw[i]});
         apb(1'b1, 8'h10, {4'h0, ow[i]});
         apb(1'b1, 8'h14, st[i]);
         apb(1'b1, 8'h18, {4'h0, un[i]});
         for (int j = 0; j < 4; j++) apb(1'b1, 8'h20 + 8'(4 * j), {j[3:0] + 4'h1, k});
         do_reset;
         `CHK("trim", cw[i][4], rc_trim_width_sel)
         `CHK("slow cpu", cw[i][3], slow_clock_cpu_allow)
         `CHK("indep start", cw[i][2], indep_dog_auto_start)
         `CHK("window start", cw[i][1], window_dog_auto_start)
         `CHK("halt bit", cw[i][0], window_dog_halt_reset)
         `CHK("ext clock", ow[i][3], ext_clock_input_sel)
         `CHK("wake sel", ow[i][2], wakeup_clock_sel)
         `CHK("prescale", ow[i][1:0], wakeup_prescale_code)
         `CHK("settle", hf[i], osc_settle_half_cycles)
         `CHK("unprotect", un[i] != 4'h5, temp_unprotect_enable)
         `CHK("keys", {4'h4, k, 4'h3, k, 4'h2, k, 4'h1, k}, {temp_unprotect_key3,
              temp_unprotect_key2, temp_unprotect_key1, temp_unprotect_key0})
         sw_start <= (i != 2);
         halt_try(cw[i][0] & (cw[i][1] | (i != 2)));
         apb(1'b0, 8'h00, 8'h00);
         `CHK("status", 32'h0000_0001, rd)
         apb(1'b1, 8'h0C, {3'b000, ~cw[i]});
         apb(1'b0, 8'h0C, 8'h00);
         `CHK("readback", {27'h000_0000, cw[i]}, rd)
         `CHK("trim held", cw[i][4], rc_trim_width_sel)
      end
   endtask

   // Verdict and end of run
   task finish_test;
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Main sequence
   initial begin
      // Option store holds 01 in every byte from power-up, so the first load is defined
      for (int i = 0; i < 16; i++) dut.u_mem.mem_q[i] = 8'h01;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_bus;
      t_decode;
      finish_test;
   end

   // Watchdog, about twenty times the expected run
   initial begin
      repeat (5000) @(posedge pclk);
      num_errors++;
      finish_test;
   end
endmodule
